// ==== rtl/msc_pkg.sv ====
// Purpose: shared constants and types of the misc system configuration bank
// Assumes: 16-bit address and data on a plain strobe port
// Notes:   addresses are the printed register offsets

package msc_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;

    // register offsets
    localparam logic [15:0] OFS_DEBUG_RUN_A  = 16'h4020;
    localparam logic [15:0] OFS_MEM_WAIT     = 16'h5320;
    localparam logic [15:0] OFS_DEBUG_RUN_B  = 16'h5322;
    localparam logic [15:0] OFS_GUARD_KEY    = 16'h5324;
    localparam logic [15:0] OFS_RAM_SIZE     = 16'h5326;
    localparam logic [15:0] OFS_VEC_LOW      = 16'h5328;
    localparam logic [15:0] OFS_VEC_HIGH     = 16'h532A;
    localparam logic [15:0] OFS_STATUS       = 16'h532C;

    // field positions
    localparam int POS_DEBUG_RUN_A   = 1;
    localparam int POS_DEBUG_RUN_B   = 0;
    localparam int POS_SRAM_REVERSE  = 12;
    localparam int POS_SRAM_WAIT     = 8;
    localparam int POS_FLASH_READ    = 0;
    localparam int POS_DEBUG_BASE    = 8;
    localparam int POS_RAM_ACT_SIZE  = 4;
    localparam int POS_RAM_SIZE      = 0;
    localparam int POS_VEC_MID       = 8;
    localparam int POS_VEC_TOP       = 0;

    // reset values
    localparam logic       RST_DEBUG_RUN    = 1'b0;
    localparam logic       RST_SRAM_REVERSE = 1'b0;
    localparam logic [1:0] RST_SRAM_WAIT    = 2'h3;
    localparam logic [2:0] RST_FLASH_READ   = 3'h3;
    localparam logic [15:0] RST_GUARD_KEY   = 16'h0000;
    localparam logic       RST_DEBUG_BASE   = 1'b0;
    localparam logic [2:0] RST_RAM_SIZE     = 3'h2;
    localparam logic [2:0] RAM_ACTUAL_SIZE  = 3'h2;
    localparam logic [7:0] RST_VEC_MID      = 8'h80;
    localparam logic [7:0] RST_VEC_TOP      = 8'h00;

    // unlock value of the guard key, arbitrary
    localparam logic [15:0] GUARD_KEY_OPEN  = 16'h0096;

    // flash code that means a single cycle
    localparam logic [2:0] FLASH_CODE_ONE   = 3'h4;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } msc_bus_req_t;

    typedef struct packed {
        logic       debug_run_sel_a;
        logic       debug_run_sel_b;
        logic       sram_bit_reverse;
        logic [1:0] sram_wait_cycles;
        logic [2:0] flash_read_cycles;
        logic       debug_base_sel;
        logic [2:0] ram_size_sel;
        logic [7:0] vector_base_mid;
        logic [7:0] vector_base_top;
    } msc_cfg_t;

    // same order as the status word bits 7..0
    typedef struct packed {
        logic [2:0] cpu_int_level;
        logic       cpu_int_enable;
        logic       carry_flag;
        logic       overflow_flag;
        logic       zero_flag;
        logic       negative_flag;
    } msc_psr_t;

    function automatic logic [2:0] msc_sram_cycles(input logic [1:0] code);
        msc_sram_cycles = 3'h2 + {1'b0, code};
    endfunction

    // reserved codes fall back to the slowest setting
    function automatic logic [2:0] msc_flash_cycles(input logic [2:0] code);
        if (code == FLASH_CODE_ONE) begin
            msc_flash_cycles = 3'h1;
        end else if (code < FLASH_CODE_ONE) begin
            msc_flash_cycles = 3'h2 + code;
        end else begin
            msc_flash_cycles = 3'h5;
        end
    endfunction

    // decoded cycle counts that the reset codes stand for, so reset loads plain constants
    localparam logic [2:0] RST_SRAM_CYCLES  = msc_sram_cycles(RST_SRAM_WAIT);
    localparam logic [2:0] RST_FLASH_CYCLES = msc_flash_cycles(RST_FLASH_READ);

endpackage

// ==== rtl/msc_guard.sv ====
// Purpose: write guard key register and unlock flag
// Assumes: key_wr_i is a decoded one-cycle write strobe
// Notes:   the unlock takes effect on the cycle after the key write

`timescale 1ns/1ps

module msc_guard (
    input  wire logic        sys_clk_i,
    input  wire logic        reset_i,
    input  wire logic        key_wr_i,
    input  wire logic [15:0] key_wdata_i,
    output logic      [15:0] key_o,
    output logic             unlocked_o
);
    import msc_pkg::*;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            key_o <= RST_GUARD_KEY;
        end else if (key_wr_i) begin
            key_o <= key_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            unlocked_o <= 1'b0;
        end else if (key_wr_i) begin
            unlocked_o <= (key_wdata_i == GUARD_KEY_OPEN);
        end
    end

endmodule // msc_guard

// ==== rtl/msc_psr_mirror.sv ====
// Purpose: registered copy of the processor status flags
// Assumes: the flags come from the core on the same clock
// Notes:   read data lag the core by two cycles, one here and one in the read register

`timescale 1ns/1ps

module msc_psr_mirror (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire msc_pkg::msc_psr_t  psr_i,
    output msc_pkg::msc_psr_t       psr_o
);
    import msc_pkg::*;

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            psr_o <= '0;
        end else begin
            psr_o <= psr_i;
        end
    end

endmodule // msc_psr_mirror

// ==== rtl/msc_regs.sv ====
// Purpose: misc system configuration register bank
// Assumes: plain strobe bus, read data in the cycle after the read strobe
// Notes:   the three registers from the ram size register upward are guarded

`timescale 1ns/1ps

module msc_regs (
    input  wire logic               sys_clk_i,
    input  wire logic               reset_i,
    input  wire logic [15:0]        addr_i,
    input  wire logic [15:0]        wr_data_i,
    input  wire logic               wr_i,
    input  wire logic               rd_i,
    input  wire msc_pkg::msc_psr_t  psr_i,
    output logic      [15:0]        rd_data_o,
    output msc_pkg::msc_cfg_t       cfg_o,
    output logic      [2:0]         sram_access_cycles_o,
    output logic      [2:0]         flash_access_cycles_o,
    output logic                    unlocked_o
);
    import msc_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // request decode

    msc_bus_req_t req;
    logic         wr_debug_a;
    logic         wr_mem_wait;
    logic         wr_debug_b;
    logic         wr_key;
    logic         wr_ram_size;
    logic         wr_vec_low;
    logic         wr_vec_high;
    logic [15:0]  key_value;
    msc_psr_t     psr_mirror;
    logic [15:0]  rd_word;
    msc_cfg_t     cfg_next;

    assign req = '{addr: addr_i, wdata: wr_data_i, wr: wr_i, rd: rd_i};

    assign wr_debug_a  = req.wr && (req.addr == OFS_DEBUG_RUN_A);
    assign wr_mem_wait = req.wr && (req.addr == OFS_MEM_WAIT);
    assign wr_debug_b  = req.wr && (req.addr == OFS_DEBUG_RUN_B);
    assign wr_key      = req.wr && (req.addr == OFS_GUARD_KEY);
    // locked writes never reach the guarded registers
    assign wr_ram_size = req.wr && (req.addr == OFS_RAM_SIZE) && unlocked_o;
    assign wr_vec_low  = req.wr && (req.addr == OFS_VEC_LOW) && unlocked_o;
    assign wr_vec_high = req.wr && (req.addr == OFS_VEC_HIGH) && unlocked_o;

    ////////////////////////////////////////////////////////////////////////////////
    // helpers

    msc_guard u_guard (
        .sys_clk_i   (sys_clk_i),
        .reset_i     (reset_i),
        .key_wr_i    (wr_key),
        .key_wdata_i (req.wdata),
        .key_o       (key_value),
        .unlocked_o  (unlocked_o)
    );

    msc_psr_mirror u_psr (
        .sys_clk_i (sys_clk_i),
        .reset_i   (reset_i),
        .psr_i     (psr_i),
        .psr_o     (psr_mirror)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // configuration fields

    always_comb begin
        cfg_next = cfg_o;
        if (wr_debug_a) begin
            cfg_next.debug_run_sel_a = req.wdata[POS_DEBUG_RUN_A];
        end
        if (wr_debug_b) begin
            cfg_next.debug_run_sel_b = req.wdata[POS_DEBUG_RUN_B];
        end
        if (wr_mem_wait) begin
            cfg_next.sram_bit_reverse  = req.wdata[POS_SRAM_REVERSE];
            cfg_next.sram_wait_cycles  = req.wdata[POS_SRAM_WAIT +: 2];
            cfg_next.flash_read_cycles = req.wdata[POS_FLASH_READ +: 3];
        end
        if (wr_ram_size) begin
            // actual size bits are read only and not taken
            cfg_next.debug_base_sel = req.wdata[POS_DEBUG_BASE];
            cfg_next.ram_size_sel   = req.wdata[POS_RAM_SIZE +: 3];
        end
        if (wr_vec_low) begin
            // low byte is fixed at zero, only the upper byte is kept
            cfg_next.vector_base_mid = req.wdata[POS_VEC_MID +: 8];
        end
        if (wr_vec_high) begin
            cfg_next.vector_base_top = req.wdata[POS_VEC_TOP +: 8];
        end
    end

    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            cfg_o.debug_run_sel_a   <= RST_DEBUG_RUN;
            cfg_o.debug_run_sel_b   <= RST_DEBUG_RUN;
            cfg_o.sram_bit_reverse  <= RST_SRAM_REVERSE;
            cfg_o.sram_wait_cycles  <= RST_SRAM_WAIT;
            cfg_o.flash_read_cycles <= RST_FLASH_READ;
            cfg_o.debug_base_sel    <= RST_DEBUG_BASE;
            cfg_o.ram_size_sel      <= RST_RAM_SIZE;
            cfg_o.vector_base_mid   <= RST_VEC_MID;
            cfg_o.vector_base_top   <= RST_VEC_TOP;
        end else begin
            cfg_o <= cfg_next;
        end
    end

    // decoded cycle counts, registered so the memory controllers see flops
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sram_access_cycles_o  <= RST_SRAM_CYCLES;
            flash_access_cycles_o <= RST_FLASH_CYCLES;
        end else begin
            sram_access_cycles_o  <= msc_sram_cycles(cfg_next.sram_wait_cycles);
            flash_access_cycles_o <= msc_flash_cycles(cfg_next.flash_read_cycles);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // read path

    always_comb begin
        rd_word = 16'h0000;
        unique case (req.addr)
            OFS_DEBUG_RUN_A: rd_word[POS_DEBUG_RUN_A] = cfg_o.debug_run_sel_a;
            OFS_MEM_WAIT: begin
                rd_word[POS_SRAM_REVERSE]    = cfg_o.sram_bit_reverse;
                rd_word[POS_SRAM_WAIT +: 2]  = cfg_o.sram_wait_cycles;
                rd_word[POS_FLASH_READ +: 3] = cfg_o.flash_read_cycles;
            end
            OFS_DEBUG_RUN_B: rd_word[POS_DEBUG_RUN_B] = cfg_o.debug_run_sel_b;
            OFS_GUARD_KEY:   rd_word = key_value;
            OFS_RAM_SIZE: begin
                rd_word[POS_DEBUG_BASE]        = cfg_o.debug_base_sel;
                rd_word[POS_RAM_ACT_SIZE +: 3] = RAM_ACTUAL_SIZE;
                rd_word[POS_RAM_SIZE +: 3]     = cfg_o.ram_size_sel;
            end
            OFS_VEC_LOW:  rd_word[POS_VEC_MID +: 8] = cfg_o.vector_base_mid;
            OFS_VEC_HIGH: rd_word[POS_VEC_TOP +: 8] = cfg_o.vector_base_top;
            OFS_STATUS:   rd_word[7:0] = psr_mirror;
            default:      rd_word = 16'h0000; // unmapped reads return zero
        endcase
    end

    // data stand only in the cycle after the strobe
    always_ff @(posedge sys_clk_i or posedge reset_i) begin
        if (reset_i) begin
            rd_data_o <= 16'h0000;
        end else if (req.rd) begin
            rd_data_o <= rd_word;
        end else begin
            rd_data_o <= 16'h0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    a_debug_a_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_debug_a |=> cfg_o.debug_run_sel_a == $past(wr_data_i[1]))
        else $error("debug run select a not taken");

    a_debug_b_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_debug_b |=> cfg_o.debug_run_sel_b == $past(wr_data_i[0]))
        else $error("debug run select b not taken");

    a_sram_wait_count:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_mem_wait |=> sram_access_cycles_o == 3'h2 + {1'b0, $past(wr_data_i[9:8])})
        else $error("sram access cycles wrong");

    a_flash_single:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_o.flash_read_cycles == 3'h4) |-> flash_access_cycles_o == 3'h1)
        else $error("flash code four must give one cycle");

    a_guard_relock:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (wr_key && wr_data_i != GUARD_KEY_OPEN) |=> !unlocked_o)
        else $error("guard did not relock");

    a_guard_locked_hold:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && addr_i == OFS_VEC_HIGH && !unlocked_o) |=> $stable(cfg_o.vector_base_top))
        else $error("locked write changed vector base");

    a_ram_actual_read:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && addr_i == OFS_RAM_SIZE) |=> rd_data_o[6:4] == 3'h2 && rd_data_o[15:9] == 7'h00)
        else $error("ram actual size read wrong");

    a_vec_mid_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_vec_low |=> cfg_o.vector_base_mid == $past(wr_data_i[15:8]))
        else $error("vector base middle byte not taken");

    a_vec_low_zero:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && addr_i == OFS_VEC_LOW) |=> rd_data_o[7:0] == 8'h00)
        else $error("vector base low byte not zero");

    a_vec_top_read:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && addr_i == OFS_VEC_HIGH) |=> rd_data_o == {8'h00, $past(cfg_o.vector_base_top)})
        else $error("vector base top read wrong");

    a_status_read:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && addr_i == OFS_STATUS) |=> rd_data_o == {8'h00, $past(psr_i, 2)})
        else $error("status mirror read wrong");

    a_reserved_zero:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && addr_i == OFS_DEBUG_RUN_B) |=> rd_data_o[15:1] == 15'h0000)
        else $error("reserved bits not zero");

    a_read_one_cycle:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        !rd_i |=> rd_data_o == 16'h0000)
        else $error("read data outside read cycle");

    a_guard_unlock:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (wr_key && wr_data_i == GUARD_KEY_OPEN) |=> unlocked_o)
        else $error("guard did not open");

    a_key_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_key |=> key_value == $past(wr_data_i))
        else $error("guard key not taken");

    a_ram_locked_hold:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && addr_i == OFS_RAM_SIZE && !unlocked_o)
        |=> $stable(cfg_o.debug_base_sel) && $stable(cfg_o.ram_size_sel))
        else $error("locked write changed ram size");

    a_vec_low_locked:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (wr_i && addr_i == OFS_VEC_LOW && !unlocked_o) |=> $stable(cfg_o.vector_base_mid))
        else $error("locked write changed vector base middle");

    a_ram_size_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_ram_size |=> cfg_o.ram_size_sel == $past(wr_data_i[2:0])
                        && cfg_o.debug_base_sel == $past(wr_data_i[8]))
        else $error("ram size fields not taken");

    a_vec_top_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_vec_high |=> cfg_o.vector_base_top == $past(wr_data_i[7:0]))
        else $error("vector base top byte not taken");

    a_sram_reverse_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_mem_wait |=> cfg_o.sram_bit_reverse == $past(wr_data_i[12])
                        && cfg_o.sram_wait_cycles == $past(wr_data_i[9:8]))
        else $error("sram fields not taken");

    a_flash_code_write:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        wr_mem_wait |=> cfg_o.flash_read_cycles == $past(wr_data_i[2:0]))
        else $error("flash code not taken");

    a_flash_normal:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_o.flash_read_cycles < 3'h4) |-> flash_access_cycles_o == cfg_o.flash_read_cycles + 3'h2)
        else $error("flash cycles wrong for normal code");

    // reserved codes are stored as written, so the decode must stay safe for them
    a_flash_reserved:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (cfg_o.flash_read_cycles > 3'h4) |-> flash_access_cycles_o == 3'h5)
        else $error("flash cycles wrong for reserved code");

    a_debug_a_read:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && addr_i == OFS_DEBUG_RUN_A) |=> rd_data_o == {14'h0000, $past(cfg_o.debug_run_sel_a), 1'b0})
        else $error("debug run select a read wrong");

    a_mem_wait_read:
    assert property (@(posedge sys_clk_i) disable iff (reset_i)
        (rd_i && addr_i == OFS_MEM_WAIT)
        |=> rd_data_o[15:13] == 3'h0 && rd_data_o[11:10] == 2'h0 && rd_data_o[7:3] == 5'h00)
        else $error("memory wait reserved bits not zero");

endmodule // msc_regs

// ==== testbench/testbench.sv ====
// Purpose: self-checking bench for the misc system configuration bank
// Assumes: plain strobe bus, read data in the cycle after the read strobe
// Notes:   a shadow model in the bench predicts every register and output

`timescale 1ns/1ps

module testbench;
    import msc_pkg::*;

    logic              sys_clk_i = 1'b0;
    logic              reset_i   = 1'b1;
    logic [15:0]       addr_i    = 16'h0000;
    logic [15:0]       wr_data_i = 16'h0000;
    logic              wr_i      = 1'b0;
    logic              rd_i      = 1'b0;
    msc_psr_t          psr_i     = '0;
    logic [15:0]       rd_data_o;
    msc_cfg_t          cfg_o;
    logic [2:0]        sram_access_cycles_o;
    logic [2:0]        flash_access_cycles_o;
    logic              unlocked_o;
    int                num_errors      = 0;
    int                samples_checked = 0;
    msc_cfg_t          e;
    logic [15:0]       ek;
    logic [15:0]       d;
    logic [15:0]       a;
    logic [15:0]       tab [9] = '{OFS_DEBUG_RUN_A, OFS_MEM_WAIT, OFS_DEBUG_RUN_B, OFS_GUARD_KEY, OFS_RAM_SIZE,
                                   OFS_VEC_LOW, OFS_VEC_HIGH, OFS_STATUS, 16'h5330};

    always #2 sys_clk_i = ~sys_clk_i;

    msc_regs u_msc_regs (
        .sys_clk_i             (sys_clk_i),
        .reset_i               (reset_i),
        .addr_i                (addr_i),
        .wr_data_i             (wr_data_i),
        .wr_i                  (wr_i),
        .rd_i                  (rd_i),
        .psr_i                 (psr_i),
        .rd_data_o             (rd_data_o),
        .cfg_o                 (cfg_o),
        .sram_access_cycles_o  (sram_access_cycles_o),
        .flash_access_cycles_o (flash_access_cycles_o),
        .unlocked_o            (unlocked_o)
    );

    ////////////////////////////////////////////////////////////////////////////
    // shadow model

    function automatic void exp_reset();
        e  = '{debug_run_sel_a: 1'b0, debug_run_sel_b: 1'b0, sram_bit_reverse: 1'b0, sram_wait_cycles: 2'h3,
               flash_read_cycles: 3'h3, debug_base_sel: 1'b0, ram_size_sel: 3'h2, vector_base_mid: 8'h80,
               vector_base_top: 8'h00};
        ek = 16'h0000;
    endfunction

    // guard is judged on the key held before this write
    function automatic void model_wr(input logic [15:0] wa, input logic [15:0] wd);
        logic unl;
        unl = (ek == GUARD_KEY_OPEN);
        case (wa)
            OFS_DEBUG_RUN_A: e.debug_run_sel_a = wd[1];
            OFS_MEM_WAIT: begin
                e.sram_bit_reverse  = wd[12];
                e.sram_wait_cycles  = wd[9:8];
                e.flash_read_cycles = wd[2:0];
            end
            OFS_DEBUG_RUN_B: e.debug_run_sel_b = wd[0];
            OFS_GUARD_KEY:   ek = wd;
            OFS_RAM_SIZE: begin
                if (unl) begin
                    e.debug_base_sel = wd[8];
                    e.ram_size_sel   = wd[2:0];
                end
            end
            OFS_VEC_LOW:  if (unl) e.vector_base_mid = wd[15:8];
            OFS_VEC_HIGH: if (unl) e.vector_base_top = wd[7:0];
            default: ;
        endcase
    endfunction

    function automatic logic [15:0] exp_rd(input logic [15:0] ra);
        case (ra)
            OFS_DEBUG_RUN_A: exp_rd = {14'h0, e.debug_run_sel_a, 1'b0};
            OFS_MEM_WAIT:    exp_rd = {3'h0, e.sram_bit_reverse, 2'h0, e.sram_wait_cycles, 5'h0, e.flash_read_cycles};
            OFS_DEBUG_RUN_B: exp_rd = {15'h0, e.debug_run_sel_b};
            OFS_GUARD_KEY:   exp_rd = ek;
            OFS_RAM_SIZE:    exp_rd = {7'h0, e.debug_base_sel, 1'b0, 3'h2, 1'b0, e.ram_size_sel};
            OFS_VEC_LOW:     exp_rd = {e.vector_base_mid, 8'h00};
            OFS_VEC_HIGH:    exp_rd = {8'h00, e.vector_base_top};
            OFS_STATUS:      exp_rd = {8'h00, psr_i};
            default:         exp_rd = 16'h0000;
        endcase
    endfunction

    // reserved codes run at the slowest setting
    function automatic logic [2:0] exp_flash(input logic [2:0] c);
        exp_flash = (c == 3'h4) ? 3'h1 : ((c < 3'h4) ? 3'h2 + c : 3'h5);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // compare and bus tasks

    task automatic fail(input string msg);
        num_errors++;
        $display("Error at %0t: %s", $time, msg);
    endtask

    task automatic chk_data(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("data %h expected %h", got, exp));
    endtask

    task automatic chk_cfg(input msc_cfg_t got, input msc_cfg_t exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("config %h expected %h", got, exp));
    endtask

    task automatic chk_cyc(input logic [2:0] got, input logic [2:0] exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("cycles %h expected %h", got, exp));
    endtask

    task automatic check_all();
        #1;
        chk_cfg(cfg_o, e);
        chk_cyc(sram_access_cycles_o, 3'h2 + {1'b0, e.sram_wait_cycles});
        chk_cyc(flash_access_cycles_o, exp_flash(e.flash_read_cycles));
        chk_data({15'h0, unlocked_o}, {15'h0, ek == GUARD_KEY_OPEN});
    endtask

    task automatic bus_wr(input logic [15:0] wa, input logic [15:0] wd);
        @(posedge sys_clk_i);
        addr_i    <= wa;
        wr_data_i <= wd;
        wr_i      <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        model_wr(wa, wd);
        check_all();
    endtask

    // read data stand only in the cycle after the strobe
    task automatic bus_rd(input logic [15:0] ra);
        @(posedge sys_clk_i);
        addr_i <= ra;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk_data(rd_data_o, exp_rd(ra));
    endtask

    task automatic do_reset();
        @(posedge sys_clk_i);
        reset_i <= 1'b1;
        wr_i    <= 1'b0;
        rd_i    <= 1'b0;
        repeat (4) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        exp_reset();
        check_all();
        foreach (tab[i]) bus_rd(tab[i]);
    endtask

    task automatic close_out();
        $display("errors %0d, comparisons %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // scenarios

    initial begin
        d = 16'($urandom(60));
        do_reset();
        @(posedge sys_clk_i);
        #1;
        chk_data(rd_data_o, 16'h0000);
        foreach (tab[i]) bus_wr(tab[i], 16'hFFFF);
        foreach (tab[i]) bus_rd(tab[i]);
        bus_wr(OFS_GUARD_KEY, GUARD_KEY_OPEN);
        // the key itself keeps the open value, or the guard would close mid-loop
        foreach (tab[i]) bus_wr(tab[i], (tab[i] == OFS_GUARD_KEY) ? GUARD_KEY_OPEN : 16'hFFFF);
        foreach (tab[i]) bus_rd(tab[i]);
        bus_wr(OFS_GUARD_KEY, GUARD_KEY_OPEN ^ 16'h0001);
        bus_wr(OFS_VEC_HIGH, 16'h0055);
        bus_wr(OFS_RAM_SIZE, 16'h0000);
        bus_rd(OFS_VEC_HIGH);
        // back to back: key write, then a guarded write in the very next cycle
        @(posedge sys_clk_i);
        addr_i    <= OFS_GUARD_KEY;
        wr_data_i <= GUARD_KEY_OPEN;
        wr_i      <= 1'b1;
        @(posedge sys_clk_i);
        addr_i    <= OFS_VEC_HIGH;
        wr_data_i <= 16'h0012;
        model_wr(OFS_GUARD_KEY, GUARD_KEY_OPEN);
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
        model_wr(OFS_VEC_HIGH, 16'h0012);
        check_all();
        bus_rd(OFS_VEC_HIGH);
        for (int i = 0; i < 8; i++) begin
            d = {3'h0, i[0], 2'h0, i[1:0], 5'h0, i[2:0]};
            bus_wr(OFS_MEM_WAIT, d);
        end
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk_i);
            psr_i <= (i < 8) ? msc_psr_t'(8'h01 << i) : msc_psr_t'(8'($urandom));
            repeat (3) @(posedge sys_clk_i);
            bus_rd(OFS_STATUS);
        end
        for (int i = 0; i < 150; i++) begin
            a = tab[$urandom_range(0, 8)];
            d = 16'($urandom);
            if (a == OFS_GUARD_KEY && $urandom_range(0, 1) == 1) d = GUARD_KEY_OPEN;
            if ($urandom_range(0, 1) == 1) begin
                bus_wr(a, d);
            end else begin
                bus_rd(a);
            end
        end
        bus_wr(OFS_GUARD_KEY, GUARD_KEY_OPEN);
        bus_wr(OFS_VEC_HIGH, 16'h00A5);
        do_reset();
        close_out();
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail("watchdog expired");
        close_out();
    end

endmodule // testbench
